// >>> rtl/ldd_core.sv
// Load identification and diagnostic reporting logic, with register slave.
// Assumes Avalon-MM master, comparator inputs synchronous to clk_in.
`timescale 1ns/1ps
`include "ldd_map.svh"

module ldd_core #(
	parameter bit HAS_CLIP_PIN = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Analog and sequencing status
	input wire logic startup_start_in,
	input wire logic startup_done_in,
	input wire logic settling_near_done_in,
	input wire logic ripple_ref_half_in,
	input wire logic ripple_cap_charged_in,
	input wire logic supply_dip_in,
	input wire logic [1:0] below_lower_trip_in,
	input wire logic [1:0] above_upper_trip_in,
	input wire logic [1:0] cur_above_hi_in,
	input wire logic [1:0] cur_below_lo_in,
	// Fault conditions, live
	input wire logic por_in,
	input wire logic low_supply_in,
	input wire logic max_temp_in,
	input wire logic [1:0] clip_in,
	input wire logic prewarn_in,
	input wire logic [1:0] short_in,
	input wire logic [1:0] spk_prot_in,
	input wire logic [1:0] offset_in,
	// Control outputs to analog side
	output logic dc_ramp_out,
	output logic clip_level_7pct_out,
	output logic prewarn_122c_out,
	// Open-drain pins
	output logic fault_flag_pin_out,
	output logic fault_flag_pin_oe_out,
	output logic clip_warn_pin_out,
	output logic clip_warn_pin_oe_out
);

	// Refuse parameter values the pin logic cannot serve
	if (HAS_CLIP_PIN !== 1'b0 && HAS_CLIP_PIN !== 1'b1) begin : g_bad_param
		$error("HAS_CLIP_PIN must be 0 or 1");
	end

	logic [7:0] control_byte_one_r;
	logic [7:0] control_byte_two_r;
	logic [7:0] control_byte_three_r;
	logic [1:0] open_r;
	logic [1:0] amp_r;
	logic [1:0] ac_r;
	logic valid_r;
	logic settled_r;
	logic [1:0] lat_ofs_r;
	logic [1:0] lat_spk_r;
	logic [1:0] lat_short_r;
	logic lat_maxt_r;
	logic lat_lowvp_r;
	logic lat_prew_r;
	logic acen_d_r;
	logic ac_run_r;
	logic [1:0] cnt0_r;
	logic [1:0] cnt1_r;
	logic [1:0] hi_d_r;
	ldd_pkg::ldd_dc_state_t dc_state_r;
	logic wait_r;
	logic acc_done;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] stat1;
	logic [7:0] stat2;
	logic [7:0] stat3;
	logic fault_live;
	logic clip_live;

	// One wait cycle, then the access completes
	assign acc_done = (avs_read_in | avs_write_in) & wait_r;
	assign wr_fire = avs_write_in & acc_done & avs_byteenable_in[0];
	assign rd_fire = avs_read_in & acc_done;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			wait_r <= 1'b0;
		else if (acc_done)
			wait_r <= 1'b0;
		else if (avs_read_in | avs_write_in)
			wait_r <= 1'b1;
	end

	// Waitrequest high until the edge before the completing edge
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			avs_waitrequest_out <= 1'b1;
		else
			avs_waitrequest_out <= !((avs_read_in | avs_write_in) &
				!wait_r);
	end

	// Control bytes, each written at its own offset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			control_byte_one_r <= `LDD_CTRL_RST;
			control_byte_two_r <= `LDD_CTRL_RST;
			control_byte_three_r <= `LDD_CTRL_RST;
		end else if (wr_fire) begin
			case (avs_address_in)
			`LDD_OFF_CTRL1: control_byte_one_r <= avs_writedata_in[7:0];
			`LDD_OFF_CTRL2: control_byte_two_r <= avs_writedata_in[7:0];
			`LDD_OFF_CTRL3: control_byte_three_r <= avs_writedata_in[7:0];
			default: ;
			endcase
		end
	end

	// Status byte images; live terms keep a fault seen at capture
	always_comb begin
		stat1 = 8'h00;
		stat2 = 8'h00;
		stat3 = 8'h00;
		stat1[`LDD_S_AC] = ac_r[0];
		stat1[`LDD_S_AMP] = amp_r[0];
		stat1[`LDD_S_OPEN] = open_r[0];
		stat1[`LDD_S_OFS] = lat_ofs_r[0] | offset_in[0];
		stat1[`LDD_S_SPK] = lat_spk_r[0] | spk_prot_in[0];
		stat1[`LDD_S_SHORT] = lat_short_r[0] | short_in[0];
		stat2[`LDD_S_AC] = ac_r[1];
		stat2[`LDD_S_AMP] = amp_r[1];
		stat2[`LDD_S_OPEN] = open_r[1];
		stat2[`LDD_S_OFS] = lat_ofs_r[1] | offset_in[1];
		stat2[`LDD_S_SPK] = lat_spk_r[1] | spk_prot_in[1];
		stat2[`LDD_S_SHORT] = lat_short_r[1] | short_in[1];
		stat3[`LDD_S3_SETTLED] = settled_r;
		stat3[`LDD_S3_VALID] = valid_r;
		stat3[`LDD_S3_MAXT] = lat_maxt_r | max_temp_in;
		stat3[`LDD_S3_LOWVP] = lat_lowvp_r | low_supply_in;
		stat3[`LDD_S3_PREW] = lat_prew_r | prewarn_in;
	end

	// Read data, captured on the edge before the completing edge
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			avs_readdata_out <= 32'h0000_0000;
		else if ((avs_read_in | avs_write_in) & !wait_r) begin
			case (avs_address_in)
			`LDD_OFF_CTRL1: avs_readdata_out <= {24'h000000,
				control_byte_one_r};
			`LDD_OFF_CTRL2: avs_readdata_out <= {24'h000000,
				control_byte_two_r};
			`LDD_OFF_CTRL3: avs_readdata_out <= {24'h000000,
				control_byte_three_r};
			`LDD_OFF_STAT1: avs_readdata_out <= {24'h000000, stat1};
			`LDD_OFF_STAT2: avs_readdata_out <= {24'h000000, stat2};
			`LDD_OFF_STAT3: avs_readdata_out <= {24'h000000, stat3};
			`LDD_OFF_LIVE: avs_readdata_out <= {30'h00000000,
				clip_live, fault_live};
			default: avs_readdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// DC detection sequencer
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			dc_state_r <= ldd_pkg::LDD_DC_IDLE;
		else begin
			case (dc_state_r)
			ldd_pkg::LDD_DC_IDLE:
				if (control_byte_one_r[`LDD_C1_DCEN] &&
					startup_start_in)
					dc_state_r <= ldd_pkg::LDD_DC_RUN;
			ldd_pkg::LDD_DC_RUN:
				if (!control_byte_one_r[`LDD_C1_DCEN])
					dc_state_r <= ldd_pkg::LDD_DC_IDLE;
				else if (startup_done_in)
					dc_state_r <= ldd_pkg::LDD_DC_DONE;
			ldd_pkg::LDD_DC_DONE:
				if (startup_start_in)
					dc_state_r <= ldd_pkg::LDD_DC_IDLE;
			default: dc_state_r <= ldd_pkg::LDD_DC_IDLE;
			endcase
		end
	end

	// Ramped offset request while measuring
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			dc_ramp_out <= 1'b0;
		else
			dc_ramp_out <= (dc_state_r == ldd_pkg::LDD_DC_RUN) &&
				control_byte_one_r[`LDD_C1_DCEN];
	end

	// Classification and valid bit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			open_r <= 2'b00;
			amp_r <= 2'b00;
			valid_r <= 1'b0;
		end else begin
			if (dc_state_r == ldd_pkg::LDD_DC_IDLE &&
				control_byte_one_r[`LDD_C1_DCEN] && startup_start_in)
				valid_r <= !ripple_cap_charged_in;
			else if (dc_state_r == ldd_pkg::LDD_DC_RUN) begin
				if (supply_dip_in)
					valid_r <= 1'b0;
				if (startup_done_in) begin
					// Short reads below lower trip: neither open nor amplifier
					open_r <= above_upper_trip_in;
					amp_r <= ~above_upper_trip_in &
						~below_lower_trip_in;
				end
			end // Otherwise held
		end
	end

	// Settled flag
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			settled_r <= 1'b0;
		else
			settled_r <= settling_near_done_in & ripple_ref_half_in;
	end

	// AC enable edge and run qualifier
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			acen_d_r <= 1'b0;
			ac_run_r <= 1'b0;
			hi_d_r <= 2'b00;
		end else begin
			acen_d_r <= control_byte_one_r[`LDD_C1_ACEN];
			hi_d_r <= cur_above_hi_in;
			if (!control_byte_one_r[`LDD_C1_ACEN])
				ac_run_r <= 1'b0;
			else if (!acen_d_r && startup_done_in &&
				dc_state_r != ldd_pkg::LDD_DC_RUN)
				ac_run_r <= 1'b1;
		end
	end

	// Crossing counters, zero while enable clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt0_r <= 2'b00;
			cnt1_r <= 2'b00;
		end else if (!control_byte_one_r[`LDD_C1_ACEN]) begin
			cnt0_r <= 2'b00;
			cnt1_r <= 2'b00;
		end else if (ac_run_r) begin
			if (cur_above_hi_in[0] && !hi_d_r[0] &&
				cnt0_r != 2'(`LDD_AC_CROSS_CNT))
				cnt0_r <= cnt0_r + 2'h1;
			if (cur_above_hi_in[1] && !hi_d_r[1] &&
				cnt1_r != 2'(`LDD_AC_CROSS_CNT))
				cnt1_r <= cnt1_r + 2'h1;
		end
	end

	// AC load bits
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			ac_r <= 2'b00;
		else if (ac_run_r) begin
			if (cnt0_r == 2'(`LDD_AC_CROSS_CNT))
				ac_r[0] <= 1'b1;
			else if (cur_below_lo_in[0])
				ac_r[0] <= 1'b0;
			if (cnt1_r == 2'(`LDD_AC_CROSS_CNT))
				ac_r[1] <= 1'b1;
			else if (cur_below_lo_in[1])
				ac_r[1] <= 1'b0;
		end
	end

	// Latched faults: set wins over read clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lat_ofs_r <= 2'b00;
			lat_spk_r <= 2'b00;
			lat_short_r <= 2'b00;
			lat_maxt_r <= 1'b0;
			lat_lowvp_r <= 1'b0;
			lat_prew_r <= 1'b0;
		end else begin
			if (rd_fire && avs_address_in == `LDD_OFF_STAT1) begin
				lat_ofs_r[0] <= offset_in[0];
				lat_spk_r[0] <= spk_prot_in[0];
				lat_short_r[0] <= short_in[0];
			end else begin
				lat_ofs_r[0] <= lat_ofs_r[0] | offset_in[0];
				lat_spk_r[0] <= lat_spk_r[0] | spk_prot_in[0];
				lat_short_r[0] <= lat_short_r[0] | short_in[0];
			end
			if (rd_fire && avs_address_in == `LDD_OFF_STAT2) begin
				lat_ofs_r[1] <= offset_in[1];
				lat_spk_r[1] <= spk_prot_in[1];
				lat_short_r[1] <= short_in[1];
			end else begin
				lat_ofs_r[1] <= lat_ofs_r[1] | offset_in[1];
				lat_spk_r[1] <= lat_spk_r[1] | spk_prot_in[1];
				lat_short_r[1] <= lat_short_r[1] | short_in[1];
			end
			if (rd_fire && avs_address_in == `LDD_OFF_STAT3) begin
				lat_maxt_r <= max_temp_in;
				lat_lowvp_r <= low_supply_in;
				lat_prew_r <= prewarn_in;
			end else begin
				lat_maxt_r <= lat_maxt_r | max_temp_in;
				lat_lowvp_r <= lat_lowvp_r | low_supply_in;
				lat_prew_r <= lat_prew_r | prewarn_in;
			end
		end
	end

	// Live pin conditions, no load detection terms
	always_comb begin
		clip_live = |clip_in | prewarn_in;
		fault_live = por_in | low_supply_in | max_temp_in |
			(control_byte_one_r[`LDD_C1_CLIP1_FAULT_FLAG_PIN] & clip_in[0]) |
			(control_byte_one_r[`LDD_C1_CLIP2_FAULT_FLAG_PIN] & clip_in[1]) |
			(control_byte_one_r[`LDD_C1_TEMP_FAULT_FLAG_PIN] & prewarn_in) |
			(!control_byte_two_r[`LDD_C2_NO_SHORT_FAULT_FLAG_PIN] &
			(|short_in | |spk_prot_in)) |
			(!control_byte_two_r[`LDD_C2_NO_OFS_FAULT_FLAG_PIN] & |offset_in);
		if (!HAS_CLIP_PIN)
			fault_live = fault_live | clip_live;
	end

	// Open-drain pins, low only while a condition is live
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			fault_flag_pin_out <= 1'b0;
			fault_flag_pin_oe_out <= 1'b0;
			clip_warn_pin_out <= 1'b0;
			clip_warn_pin_oe_out <= 1'b0;
		end else begin
			fault_flag_pin_oe_out <= fault_live;
			clip_warn_pin_oe_out <= clip_live & HAS_CLIP_PIN;
		end
	end

	// Level selects to the analog detectors
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			clip_level_7pct_out <= 1'b0;
			prewarn_122c_out <= 1'b0;
		end else begin
			clip_level_7pct_out <= control_byte_two_r[`LDD_C2_CLIP_LVL];
			prewarn_122c_out <= control_byte_three_r[`LDD_C3_TEMP_LVL];
		end
	end

endmodule

// >>> include/ldd_map.svh
// Register map and field positions for the load detect / diagnostic block.
// Assumes Avalon-MM word addressing of byte-wide registers in the low bits.
`ifndef LDD_MAP_SVH
`define LDD_MAP_SVH

// Word offsets (byte address = 4 * index)
`define LDD_OFF_CTRL1 4'h0
`define LDD_OFF_CTRL2 4'h1
`define LDD_OFF_CTRL3 4'h2
`define LDD_OFF_STAT1 4'h3
`define LDD_OFF_STAT2 4'h4
`define LDD_OFF_STAT3 4'h5
`define LDD_OFF_LIVE 4'h6

// Control byte one fields
`define LDD_C1_ACEN 2
`define LDD_C1_DCEN 1
`define LDD_C1_TEMP_FAULT_FLAG_PIN 4
`define LDD_C1_CLIP2_FAULT_FLAG_PIN 5
`define LDD_C1_CLIP1_FAULT_FLAG_PIN 6
// Control byte two fields
`define LDD_C2_CLIP_LVL 7
`define LDD_C2_NO_SHORT_FAULT_FLAG_PIN 4
`define LDD_C2_NO_OFS_FAULT_FLAG_PIN 1
// Control byte three fields
`define LDD_C3_TEMP_LVL 4

// Channel status byte fields
`define LDD_S_AC 7
`define LDD_S_AMP 5
`define LDD_S_OPEN 4
`define LDD_S_OFS 2
`define LDD_S_SPK 1
`define LDD_S_SHORT 0
// Status byte three fields
`define LDD_S3_SETTLED 4
`define LDD_S3_VALID 3
`define LDD_S3_MAXT 2
`define LDD_S3_LOWVP 1
`define LDD_S3_PREW 0

`define LDD_CTRL_RST 8'h00
`define LDD_AC_CROSS_CNT 3
`define LDD_BUS_WAIT 1

`endif

// >>> include/ldd_pkg.sv
// Types for the load detect / diagnostic block.
// Assumes nothing beyond a SystemVerilog compiler.
package ldd_pkg;
	typedef enum logic [1:0] {
		LDD_DC_IDLE = 2'b00,
		LDD_DC_RUN = 2'b01,
		LDD_DC_DONE = 2'b11
	} ldd_dc_state_t;
endpackage

// >>> test/ldd_host.sv
// Host model: Avalon-MM master for the diagnostic register block.
// Assumes a slave with waitrequest, sampled on clk_in rising edges.
`timescale 1ns/1ps
module ldd_host (
	input wire logic clk_in,
	output logic [3:0] adr_out,
	output logic rd_out,
	output logic wr_out,
	output logic [31:0] wd_out,
	output logic [3:0] be_out,
	input wire logic [31:0] rdata_in,
	input wire logic wait_in,
	output logic hung_out
);
	// Idle bus at time zero
	initial begin
		{adr_out, rd_out, wr_out, wd_out, hung_out} = '0;
		be_out = 4'hF;
	end
	// One cycle, held until waitrequest is sampled low
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		adr_out <= a;
		wd_out <= {24'h0, d};
		wr_out <= w;
		rd_out <= !w;
		@(posedge clk_in);
		while (wait_in && n < 40) begin
			n++;
			@(posedge clk_in);
		end
		hung_out <= hung_out | wait_in; // Sticky: a later good cycle hides none
		q = rdata_in[7:0];
		rd_out <= 1'b0;
		wr_out <= 1'b0;
		wd_out <= ~wd_out; // Released data does not keep its value
		@(posedge clk_in);
	endtask
	// Control bytes go out in order one, two, three
	task automatic ctl(input logic [7:0] c1, c2, c3);
		logic [7:0] q;
		xfer(1'b1, 4'h0, c1, q);
		xfer(1'b1, 4'h1, c2, q);
		xfer(1'b1, 4'h2, c3, q);
	endtask
endmodule

// >>> test/ldd_core_monitor.sv
// Checker for bus timing, pin logic and level outputs of ldd_core.
// Assumes it is bound into every ldd_core instance.
`timescale 1ns/1ps
module ldd_core_monitor #(
	parameter bit HAS_CLIP_PIN = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic por_in,
	input wire logic low_supply_in,
	input wire logic max_temp_in,
	input wire logic [1:0] clip_in,
	input wire logic prewarn_in,
	input wire logic [1:0] short_in,
	input wire logic [1:0] spk_prot_in,
	input wire logic [1:0] offset_in,
	input wire logic clip_level_7pct_out,
	input wire logic prewarn_122c_out,
	input wire logic fault_flag_pin_out,
	input wire logic fault_flag_pin_oe_out,
	input wire logic clip_warn_pin_out,
	input wire logic clip_warn_pin_oe_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Any live fault source present
	logic any_src;
	assign any_src = por_in | low_supply_in | max_temp_in | (|clip_in) |
		prewarn_in | (|short_in) | (|spk_prot_in) | (|offset_in);
	// Bus answers
	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) &&
		avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer not after one wait cycle");
	a_wait_low_once: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_idle_wait_high: assert property (
		!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
		else $error("waitrequest low without request");
	// Pin logic
	a_pin_drive_low: assert property (
		!fault_flag_pin_out && !clip_warn_pin_out)
		else $error("pin driven high");
	a_fault_fixed_src: assert property (
		por_in || low_supply_in || max_temp_in |=> fault_flag_pin_oe_out)
		else $error("fixed source missing on fault pin");
	a_fault_release: assert property (!any_src |=>
		!fault_flag_pin_oe_out)
		else $error("fault pin held without source");
	a_clip_follow: assert property (1'b1 |=>
		clip_warn_pin_oe_out == (HAS_CLIP_PIN && $past(prewarn_in || (|clip_in))))
		else $error("clip pin not clip or prewarning");
	// Level outputs move only after a write
	a_level_hold: assert property (
		!$past(avs_write_in) && !$past(avs_write_in, 2) |->
		$stable(clip_level_7pct_out) && $stable(prewarn_122c_out))
		else $error("level output changed without write");
	c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
	c_fault_on: cover property ($rose(fault_flag_pin_oe_out));
	c_clip_on: cover property ($rose(clip_warn_pin_oe_out));
endmodule
bind ldd_core ldd_core_monitor #(.HAS_CLIP_PIN(HAS_CLIP_PIN)) u_mon (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.por_in(por_in), .low_supply_in(low_supply_in), .max_temp_in(max_temp_in),
	.clip_in(clip_in), .prewarn_in(prewarn_in), .short_in(short_in),
	.spk_prot_in(spk_prot_in), .offset_in(offset_in),
	.clip_level_7pct_out(clip_level_7pct_out),
	.prewarn_122c_out(prewarn_122c_out),
	.fault_flag_pin_out(fault_flag_pin_out),
	.fault_flag_pin_oe_out(fault_flag_pin_oe_out),
	.clip_warn_pin_out(clip_warn_pin_out),
	.clip_warn_pin_oe_out(clip_warn_pin_oe_out));

// >>> test/ldd_core_test.sv
// Testbench for ldd_core: bus cycles, pin logic, DC and AC detection.
// Assumes ldd_host as bus master and the bound ldd_core_monitor.
`timescale 1ns/1ps
`include "ldd_map.svh"
module ldd_core_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic por = 1'b0, lowv = 1'b0, maxt = 1'b0, prew = 1'b0;
	logic [1:0] clip = 2'h0, shrt = 2'h0, spk = 2'h0, ofs = 2'h0;
	logic start = 1'b0, done = 1'b0, settle = 1'b0, half = 1'b0;
	logic charged = 1'b0, dip = 1'b0;
	logic [1:0] below = 2'h0, above = 2'h0, hi = 2'h0, lo = 2'h0;
	logic [3:0] adr, be;
	logic rd, wr, wreq, hung, ramp, lvl7, t122, fpin, foe, cpin, coe;
	logic foe_nc, coe_nc;
	logic [31:0] wd, rdata;
	logic [7:0] q;
	int error_cnt = 0;
	int samples_checked = 0;
	// Fault-pin cases: ctrl1, ctrl2, sources, fault oe, clip oe
	logic [29:0] rows [14] = '{
		{8'h00,8'h00,12'h800,2'h2}, {8'h00,8'h00,12'h400,2'h2},
		{8'h00,8'h00,12'h200,2'h2}, {8'h00,8'h00,12'h040,2'h1},
		{8'h40,8'h00,12'h040,2'h3}, {8'h20,8'h00,12'h040,2'h1},
		{8'h20,8'h00,12'h080,2'h3}, {8'h10,8'h00,12'h100,2'h3},
		{8'h00,8'h00,12'h020,2'h2}, {8'h00,8'h10,12'h024,2'h0},
		{8'h00,8'h00,12'h008,2'h2}, {8'h00,8'h02,12'h001,2'h0},
		{8'h00,8'h80,12'h002,2'h2}, {8'h00,8'h00,12'h000,2'h0}};
	// 40 MHz clock
	always #12.5 clk = ~clk;
	ldd_host u_host (.clk_in(clk), .adr_out(adr), .rd_out(rd), .wr_out(wr),
		.wd_out(wd), .be_out(be), .rdata_in(rdata), .wait_in(wreq),
		.hung_out(hung));
	ldd_core u_dut (.clk_in(clk), .rst_n_in(rst_n), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .startup_start_in(start),
		.startup_done_in(done), .settling_near_done_in(settle),
		.ripple_ref_half_in(half), .ripple_cap_charged_in(charged),
		.supply_dip_in(dip), .below_lower_trip_in(below),
		.above_upper_trip_in(above), .cur_above_hi_in(hi),
		.cur_below_lo_in(lo), .por_in(por), .low_supply_in(lowv),
		.max_temp_in(maxt), .clip_in(clip), .prewarn_in(prew),
		.short_in(shrt), .spk_prot_in(spk), .offset_in(ofs),
		.dc_ramp_out(ramp), .clip_level_7pct_out(lvl7),
		.prewarn_122c_out(t122), .fault_flag_pin_out(fpin),
		.fault_flag_pin_oe_out(foe), .clip_warn_pin_out(cpin),
		.clip_warn_pin_oe_out(coe));
	// Second copy without the clip pin, same bus and sources
	ldd_core #(.HAS_CLIP_PIN(1'b0)) u_dut_noclip (.clk_in(clk),
		.rst_n_in(rst_n), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(),
		.avs_waitrequest_out(), .startup_start_in(start),
		.startup_done_in(done), .settling_near_done_in(settle),
		.ripple_ref_half_in(half), .ripple_cap_charged_in(charged),
		.supply_dip_in(dip), .below_lower_trip_in(below),
		.above_upper_trip_in(above), .cur_above_hi_in(hi),
		.cur_below_lo_in(lo), .por_in(por), .low_supply_in(lowv),
		.max_temp_in(maxt), .clip_in(clip), .prewarn_in(prew),
		.short_in(shrt), .spk_prot_in(spk), .offset_in(ofs),
		.dc_ramp_out(), .clip_level_7pct_out(),
		.prewarn_122c_out(), .fault_flag_pin_out(),
		.fault_flag_pin_oe_out(foe_nc), .clip_warn_pin_out(),
		.clip_warn_pin_oe_out(coe_nc));
	// Compare, count, report; a hung bus ends the run
	task automatic chk(input string n, input logic [7:0] e, s);
		samples_checked++;
		if (hung !== 1'b0 || s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
		if (hung !== 1'b0) wrap_up();
	endtask
	// Masked register read and compare
	task automatic rdc(input logic [3:0] a, input logic [7:0] m, e,
		input string n);
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(n, e, q & m);
	endtask
	task automatic wrr(input logic [3:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, d, q);
	endtask
	// Start-up pulse, then current threshold pulses
	task automatic kick();
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic pls(input logic [1:0] h, l);
		hi <= h;
		lo <= l;
		@(posedge clk);
		hi <= 2'h0;
		lo <= 2'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		logic [7:0] c1, c2;
		logic [11:0] src;
		logic ef, ec;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("fault_oe", 8'h00, foe);
		for (int a = 0; a < 3; a++) begin
			rdc(4'(a), 8'hFF, 8'h00, "ctrl_reset");
		end
		rdc(4'h7, 8'hFF, 8'h00, "unmapped");
		// Latched short, live pin released
		shrt <= 2'h1;
		repeat (3) @(posedge clk);
		shrt <= 2'h0;
		repeat (3) @(posedge clk);
		chk("fault_rel", 8'h00, foe);
		rdc(`LDD_OFF_STAT1, 8'h01, 8'h01, "latched");
		rdc(`LDD_OFF_STAT1, 8'h01, 8'h00, "reread");
		// DC run: ch1 open, ch2 shorted
		{settle, half, below, above} <= 6'h39;
		kick();
		chk("ramp_off", 8'h00, ramp);
		wrr(`LDD_OFF_CTRL1, 8'h02);
		kick();
		chk("ramp_on", 8'h01, ramp);
		done <= 1'b1;
		repeat (2) @(posedge clk);
		rdc(`LDD_OFF_STAT1, 8'h30, 8'h10, "ch1");
		rdc(`LDD_OFF_STAT1, 8'h30, 8'h10, "ch1_hold");
		rdc(`LDD_OFF_STAT2, 8'h30, 8'h00, "ch2");
		rdc(`LDD_OFF_STAT3, 8'h18, 8'h18, "valid");
		// DC run with charged ripple cap: line driver, invalid
		{done, charged, below, above} <= 6'h10;
		kick();
		kick();
		done <= 1'b1;
		repeat (2) @(posedge clk);
		rdc(`LDD_OFF_STAT1, 8'h30, 8'h20, "line");
		rdc(`LDD_OFF_STAT3, 8'h08, 8'h00, "invalid");
		// AC detection on ch1
		wrr(`LDD_OFF_CTRL1, 8'h06);
		pls(2'h1, 2'h0);
		pls(2'h1, 2'h0);
		rdc(`LDD_OFF_STAT1, 8'h80, 8'h00, "ac_two");
		pls(2'h1, 2'h0);
		rdc(`LDD_OFF_STAT1, 8'h80, 8'h80, "ac_three");
		rdc(`LDD_OFF_STAT2, 8'h80, 8'h00, "ac_ch2");
		wrr(`LDD_OFF_CTRL1, 8'h02);
		wrr(`LDD_OFF_CTRL1, 8'h06);
		pls(2'h0, 2'h1);
		pls(2'h1, 2'h0);
		pls(2'h1, 2'h0);
		rdc(`LDD_OFF_STAT1, 8'h80, 8'h00, "ac_clr");
		// Pin table with load comparators active
		{below, above, hi, lo} <= 8'hFF;
		foreach (rows[i]) begin
			{c1, c2, src, ef, ec} = rows[i];
			u_host.ctl(c1, c2, 8'h00);
			{por, lowv, maxt, prew, clip, shrt, spk, ofs} <= src;
			repeat (3) @(posedge clk);
			chk("fault_oe", ef, foe);
			chk("clip_oe", ec, coe);
			chk("clip_lvl", c2[7], lvl7);
			chk("fault_oe_nc", ef | ec, foe_nc);
			chk("clip_oe_nc", 8'h00, coe_nc);
			rdc(`LDD_OFF_LIVE, 8'h03, {6'h00, ec, ef}, "live");
		end
		u_host.ctl(8'h00, 8'h00, 8'h10);
		repeat (2) @(posedge clk);
		chk("t122", 8'h01, t122);
		// Mid-run reset returns control bytes and levels to zero
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("t122_rst", 8'h00, t122);
		rdc(`LDD_OFF_CTRL3, 8'hFF, 8'h00, "ctrl3_rst");
		wrap_up();
	end
endmodule
